//--- include/pmg_pkg.sv
package pmg_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00; // enable, mode, sticky, violation action
    localparam logic [7:0] OFF_MAX = 8'h04; // dynamic secure address limit
    localparam logic [7:0] OFF_RECOV = 8'h08; // recovery interval in seconds
    localparam logic [7:0] OFF_AGE = 8'h0c; // shared mac table age in seconds
    localparam logic [7:0] OFF_ENTRY = 8'h10; // static entry staging: mac low word
    localparam logic [7:0] OFF_ENTRY_HI = 8'h14; // mac upper 16 bits, vlan, kind
    localparam logic [7:0] OFF_CMD = 8'h18; // entry and admin up/down commands
    localparam logic [7:0] OFF_STATUS = 8'h1c; // port state, count
    localparam logic [7:0] OFF_ACCESS_VLAN = 8'h20; // access vlan
    // control field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_TRUNK = 1;
    localparam int CTRL_STICKY = 2;
    localparam int CTRL_RESTRICT = 3;
    localparam int CTRL_AUTO_RECOV = 4;
    localparam int CTRL_AGE_EN = 5;
    // command field positions
    localparam int CMD_ADD = 0;
    localparam int CMD_CLEAR_ALL = 1;
    localparam int CMD_ADMIN_UP = 2;
    localparam int CMD_ADMIN_DOWN = 3;
    // reset values and limits
    localparam logic [13:0] MAX_DYN_LIMIT = 14'd8192;
    localparam logic [15:0] RECOV_RESET = 16'h0000;
    localparam logic [15:0] AGE_RESET = 16'd300;
    localparam logic [11:0] VLAN_DEFAULT = 12'h001;
    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int SECOND_CYCLES = CLK_HZ;
    // entry kinds
    typedef enum logic [1:0] {
        PMG_FREE = 2'b00,
        PMG_DYN = 2'b01,
        PMG_STICKY = 2'b10,
        PMG_STATIC = 2'b11
    } pmg_kind_e;
    // port guard states
    typedef enum logic [1:0] {
        PMG_UP = 2'b00,
        PMG_SHUT = 2'b01,
        PMG_RECOVER = 2'b10
    } pmg_port_e;
endpackage : pmg_pkg

//--- src/pmg_tick.sv
module pmg_tick #(
    parameter int CYCLES = 50_000_000
) (
    input wire logic MCLK,
    input wire logic RST,
    output logic TICK
);
    import pmg_pkg::*;
    typedef struct packed {
        logic [31:0] cnt; // cycles into the current second
        logic tick; // one-cycle pulse each second
    } pmg_tick_s;
    pmg_tick_s r, next_r;
    // second divider
    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        if (r.cnt == 32'(CYCLES - 1)) begin
            next_r.cnt = 32'h0;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + 32'h1;
        end
    end
    always_ff @(posedge MCLK) begin
        if (RST) r <= '0;
        else r <= next_r;
    end
    assign TICK = r.tick;
endmodule : pmg_tick

//--- src/pmg_apb.sv
module pmg_apb (
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    output logic WR_STB,
    output logic RD_STB,
    output logic PSLVERR,
    output logic PREADY
);
    import pmg_pkg::*;
    logic hit; // address maps to a register
    // decode and single-cycle access
    always_comb begin
        hit = 1'b0;
        unique case (PADDR)
            OFF_CTRL, OFF_MAX, OFF_RECOV, OFF_AGE, OFF_ENTRY, OFF_ENTRY_HI,
            OFF_CMD, OFF_STATUS, OFF_ACCESS_VLAN: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign PREADY = 1'b1;
    assign WR_STB = PSEL & PENABLE & PWRITE & hit;
    assign RD_STB = PSEL & PENABLE & ~PWRITE;
    assign PSLVERR = PSEL & PENABLE & ~hit;
endmodule : pmg_apb

//--- src/pmg_guard.sv
// Notes on behaviour
// - forward only sources matching secure entries
// - violation when full and source unknown
// - shutdown: port down, drop all, event
// - restrict: drop violators, stop learning, logical off
// - move between secured ports is no violation
// - auto recovery timer in seconds
// - optional aging removes inactive entries
// - link down drops dynamic, keeps static sticky
// - static entry vlan: access vlan or explicit
// - sticky on converts dynamic, learns sticky
// - sticky off converts sticky back dynamic
// - only dynamic entries migrate away
// - aging uses shared table age value
// - dynamic limit at most 8192, default 8192
// - recovery keeps guard configuration
// - violation shutdown survives device restart
// - violation and admin shutdown tracked apart
// - mode change refused while guard enabled
// - config change while shut stops recovery timer; code: only an OFF_CTRL write stops it
// - new recovery interval restarts timer
//
// Register access over APB and the register offsets were left to the implementer.
module pmg_guard #(
    parameter int ENTRIES = 8, // table depth held in this port
    parameter int TICK_CYCLES = pmg_pkg::SECOND_CYCLES // cycles per second
) (
    input wire logic MCLK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // persisted violation state, kept by always-on logic outside
    input wire logic SHUT_PERSIST_IN,
    output logic SHUT_PERSIST_OUT,
    // ingress frame source, one-cycle strobe
    input wire logic FRM_VALID,
    input wire logic [47:0] FRM_SRC,
    input wire logic [11:0] FRM_VLAN,
    input wire logic LINK_UP,
    // source seen on another port (move notice)
    input wire logic MOVE_VALID,
    input wire logic [47:0] MOVE_SRC,
    // verdict, one cycle after the frame
    output logic FWD_VALID,
    output logic FWD_OK,
    output logic VIOL_EVENT,
    output logic PORT_ENABLE,
    output logic LOGICAL_ENABLE
);
    import pmg_pkg::*;
    typedef struct packed {
        logic [47:0] mac;
        logic [11:0] vlan;
        pmg_kind_e kind;
        logic [15:0] idle; // seconds since last seen
    } pmg_ent_s;
    typedef struct packed {
        pmg_ent_s [ENTRIES-1:0] tab; // secure address table
        logic [5:0] ctrl;
        logic [13:0] max_dyn;
        logic [15:0] recov;
        logic [15:0] age;
        logic [11:0] access_vlan;
        logic [31:0] stage_lo;
        logic [31:0] stage_hi;
        pmg_port_e pst;
        logic admin_down;
        logic [15:0] timer;
        logic [13:0] count;
        logic fwd_valid;
        logic fwd_ok;
        logic viol;
        logic restricted;
        logic link_q;
        logic strap_done;
        logic [31:0] rdata;
        logic mode_err;
    } pmg_st_s;
    pmg_st_s r, next_r;
    logic wr_stb, rd_stb, tick;
    logic hit_any, full, learn_ok;
    logic [$clog2(ENTRIES)-1:0] hit_idx, free_idx;
    logic free_any;
    logic [13:0] cnt_now;
    // entry matches source and vlan: frame vlan on trunk, access vlan otherwise
    function automatic logic ent_match(input pmg_ent_s e, input logic [47:0] m,
            input logic [11:0] v);
        ent_match = (e.kind != PMG_FREE) && (e.mac == m) && (e.vlan == v);
    endfunction : ent_match
    pmg_apb u_apb (
        .PSEL(PSEL),
        .PENABLE(PENABLE),
        .PWRITE(PWRITE),
        .PADDR(PADDR),
        .WR_STB(wr_stb),
        .RD_STB(rd_stb),
        .PSLVERR(PSLVERR),
        .PREADY(PREADY)
    );
    pmg_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .MCLK(MCLK),
        .RST(RST),
        .TICK(tick)
    );
    // table lookup for the arriving frame
    always_comb begin
        hit_any = 1'b0;
        hit_idx = '0;
        free_any = 1'b0;
        free_idx = '0;
        cnt_now = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (ent_match(r.tab[i], FRM_SRC, r.ctrl[CTRL_TRUNK] ? FRM_VLAN : r.access_vlan)) begin
                hit_any = 1'b1;
                hit_idx = i[$clog2(ENTRIES)-1:0];
            end
            if (r.tab[i].kind == PMG_FREE && !free_any) begin
                free_any = 1'b1;
                free_idx = i[$clog2(ENTRIES)-1:0];
            end
            if (r.tab[i].kind == PMG_DYN || r.tab[i].kind == PMG_STICKY) begin
                cnt_now = cnt_now + 14'h1;
            end
        end
    end
    // full when count reaches limit or no slot left
    assign full = (r.count >= r.max_dyn) || !free_any;
    assign learn_ok = !full && !r.restricted;
    // main next-state logic
    always_comb begin
        next_r = r;
        next_r.fwd_valid = 1'b0;
        next_r.viol = 1'b0;
        next_r.link_q = LINK_UP;
        next_r.count = cnt_now;
        // restrict lifts once count drops below limit
        if (r.restricted && r.count < r.max_dyn) begin
            next_r.restricted = 1'b0;
        end
        // violation shutdown caught after reset release
        if (!r.strap_done) begin
            next_r.strap_done = 1'b1;
            if (SHUT_PERSIST_IN) next_r.pst = PMG_SHUT;
        end
        // frame verdict
        if (FRM_VALID) begin
            next_r.fwd_valid = 1'b1;
            if (!r.ctrl[CTRL_EN]) begin
                next_r.fwd_ok = (r.pst == PMG_UP) && !r.admin_down;
            end else if (r.pst != PMG_UP || r.admin_down) begin
                next_r.fwd_ok = 1'b0;
            end else if (hit_any) begin
                next_r.fwd_ok = 1'b1;
                next_r.tab[hit_idx].idle = '0;
            end else if (learn_ok) begin
                next_r.fwd_ok = 1'b1;
                next_r.tab[free_idx].mac = FRM_SRC;
                next_r.tab[free_idx].vlan = r.ctrl[CTRL_TRUNK] ? FRM_VLAN : r.access_vlan;
                next_r.tab[free_idx].kind = r.ctrl[CTRL_STICKY] ? PMG_STICKY : PMG_DYN;
                next_r.tab[free_idx].idle = '0;
            end else begin
                next_r.fwd_ok = 1'b0;
                if (full) begin
                    // restrict drops silently, only shutdown raises the event
                    if (r.ctrl[CTRL_RESTRICT]) begin
                        next_r.restricted = 1'b1;
                    end else begin
                        next_r.viol = 1'b1;
                        next_r.pst = r.ctrl[CTRL_AUTO_RECOV] ? PMG_RECOVER : PMG_SHUT;
                        next_r.timer = r.recov;
                    end
                end
            end
        end
        // source moved away: only dynamic entries follow it
        if (MOVE_VALID) begin
            for (int i = 0; i < ENTRIES; i++) begin
                if (r.tab[i].kind == PMG_DYN && r.tab[i].mac == MOVE_SRC) begin
                    next_r.tab[i].kind = PMG_FREE;
                end
            end
        end
        // link down drops dynamic entries
        if (r.link_q && !LINK_UP) begin
            for (int i = 0; i < ENTRIES; i++) begin
                if (r.tab[i].kind == PMG_DYN) next_r.tab[i].kind = PMG_FREE;
            end
        end
        // seconds: aging and recovery countdown
        if (tick) begin
            for (int i = 0; i < ENTRIES; i++) begin
                if (r.tab[i].kind != PMG_FREE && r.tab[i].kind != PMG_STATIC) begin
                    if (r.ctrl[CTRL_AGE_EN] && r.tab[i].idle >= r.age) begin
                        next_r.tab[i].kind = PMG_FREE;
                    end else if (r.tab[i].idle != 16'hffff) begin
                        next_r.tab[i].idle = r.tab[i].idle + 16'h1;
                    end
                end
            end
            if (r.pst == PMG_RECOVER) begin
                if (r.timer <= 16'h1) next_r.pst = PMG_UP;
                else next_r.timer = r.timer - 16'h1;
            end
        end
        // register writes
        next_r.mode_err = 1'b0;
        if (wr_stb) begin
            unique case (PADDR)
                OFF_CTRL: begin
                    next_r.ctrl = PWDATA[5:0];
                    if (r.ctrl[CTRL_EN] && PWDATA[CTRL_TRUNK] != r.ctrl[CTRL_TRUNK]) begin
                        next_r.ctrl[CTRL_TRUNK] = r.ctrl[CTRL_TRUNK];
                        next_r.mode_err = 1'b1;
                    end
                    for (int i = 0; i < ENTRIES; i++) begin
                        if (PWDATA[CTRL_STICKY] && r.tab[i].kind == PMG_DYN)
                            next_r.tab[i].kind = PMG_STICKY;
                        if (!PWDATA[CTRL_STICKY] && r.tab[i].kind == PMG_STICKY)
                            next_r.tab[i].kind = PMG_DYN;
                    end
                    if (r.pst == PMG_RECOVER) next_r.pst = PMG_SHUT;
                end
                OFF_MAX: begin
                    if (PWDATA[13:0] == 14'h0 || PWDATA[31:0] > 32'(MAX_DYN_LIMIT))
                        next_r.max_dyn = MAX_DYN_LIMIT;
                    else next_r.max_dyn = PWDATA[13:0];
                end
                OFF_RECOV: begin
                    next_r.recov = PWDATA[15:0];
                    if (r.pst != PMG_UP) begin
                        next_r.pst = PMG_RECOVER;
                        next_r.timer = PWDATA[15:0];
                    end
                end
                OFF_AGE: next_r.age = PWDATA[15:0];
                OFF_ACCESS_VLAN: next_r.access_vlan = PWDATA[11:0];
                OFF_ENTRY: next_r.stage_lo = PWDATA;
                OFF_ENTRY_HI: next_r.stage_hi = PWDATA;
                OFF_CMD: begin
                    if (PWDATA[CMD_ADD] && free_any) begin
                        next_r.tab[free_idx].mac = {r.stage_hi[15:0], r.stage_lo};
                        next_r.tab[free_idx].vlan = r.ctrl[CTRL_TRUNK] ? r.stage_hi[27:16]
                            : r.access_vlan;
                        next_r.tab[free_idx].kind = r.stage_hi[28] ? PMG_STICKY : PMG_STATIC;
                        next_r.tab[free_idx].idle = '0;
                    end
                    if (PWDATA[CMD_CLEAR_ALL]) begin
                        for (int i = 0; i < ENTRIES; i++) next_r.tab[i].kind = PMG_FREE;
                    end
                    if (PWDATA[CMD_ADMIN_UP]) begin
                        next_r.admin_down = 1'b0;
                        next_r.pst = PMG_UP; // manual restore
                        next_r.restricted = 1'b0;
                    end
                    if (PWDATA[CMD_ADMIN_DOWN]) next_r.admin_down = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // read data
        if (rd_stb) begin
            unique case (PADDR)
                OFF_CTRL: next_r.rdata = {26'h0, r.ctrl};
                OFF_MAX: next_r.rdata = {18'h0, r.max_dyn};
                OFF_RECOV: next_r.rdata = {16'h0, r.recov};
                OFF_AGE: next_r.rdata = {16'h0, r.age};
                OFF_ENTRY: next_r.rdata = r.stage_lo;
                OFF_ENTRY_HI: next_r.rdata = r.stage_hi;
                OFF_STATUS: next_r.rdata = {r.timer, r.mode_err, r.restricted,
                    r.admin_down, r.pst[1:0], r.count[10:0]};
                OFF_ACCESS_VLAN: next_r.rdata = {20'h0, r.access_vlan};
                default: next_r.rdata = 32'h0;
            endcase
        end
    end
    // state register
    always_ff @(posedge MCLK) begin
        if (RST) begin
            r <= '0;
            r.max_dyn <= MAX_DYN_LIMIT;
            r.recov <= RECOV_RESET;
            r.age <= AGE_RESET;
            r.access_vlan <= VLAN_DEFAULT;
            r.link_q <= 1'b1;
        end else begin
            r <= next_r;
        end
    end
    // read data is combinational from registers during access phase
    always_comb begin
        PRDATA = 32'h0;
        if (rd_stb) begin
            unique case (PADDR)
                OFF_CTRL: PRDATA = {26'h0, r.ctrl};
                OFF_MAX: PRDATA = {18'h0, r.max_dyn};
                OFF_RECOV: PRDATA = {16'h0, r.recov};
                OFF_AGE: PRDATA = {16'h0, r.age};
                OFF_ENTRY: PRDATA = r.stage_lo;
                OFF_ENTRY_HI: PRDATA = r.stage_hi;
                OFF_STATUS: PRDATA = {r.timer, r.mode_err, r.restricted, r.admin_down,
                    r.pst[1:0], r.count[10:0]};
                OFF_ACCESS_VLAN: PRDATA = {20'h0, r.access_vlan};
                default: PRDATA = 32'h0;
            endcase
        end
    end
    // outputs
    assign FWD_VALID = r.fwd_valid;
    assign FWD_OK = r.fwd_ok;
    assign VIOL_EVENT = r.viol;
    assign PORT_ENABLE = (r.pst == PMG_UP) && !r.admin_down;
    assign LOGICAL_ENABLE = PORT_ENABLE && !r.restricted;
    assign SHUT_PERSIST_OUT = (r.pst != PMG_UP);
endmodule : pmg_guard

//--- bench/pmg_guard_sva.sv
module pmg_guard_sva (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic FRM_VALID,
    input wire logic FWD_VALID,
    input wire logic FWD_OK,
    input wire logic VIOL_EVENT,
    input wire logic PORT_ENABLE,
    input wire logic LOGICAL_ENABLE,
    input wire logic SHUT_PERSIST_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    // one clock domain, reset masks every check
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    a_verdict_follows: assert property (FRM_VALID |=> FWD_VALID)
        else $error("frame without verdict");
    a_no_spare_verdict: assert property (!FRM_VALID |=> !FWD_VALID)
        else $error("verdict without frame");
    a_event_drops_frame: assert property (VIOL_EVENT |-> FWD_VALID && !FWD_OK)
        else $error("violation frame forwarded");
    a_shut_drops_all: assert property (FRM_VALID && !PORT_ENABLE |=> !FWD_OK)
        else $error("frame forwarded on shut port");
    a_event_stops_logic: assert property (VIOL_EVENT |-> ##[0:1] !LOGICAL_ENABLE)
        else $error("logical side still on after violation");
    a_logic_needs_port: assert property (!PORT_ENABLE |-> !LOGICAL_ENABLE)
        else $error("logical side on while port down");
    a_persist_means_shut: assert property (SHUT_PERSIST_OUT |-> !PORT_ENABLE)
        else $error("persisted shut but port up");
    a_ready_zero_wait: assert property (PSEL && PENABLE |-> PREADY)
        else $error("access phase stalled");
    a_slverr_in_access: assert property (PSLVERR |-> PSEL && PENABLE)
        else $error("slave error outside access phase");
endmodule : pmg_guard_sva

bind pmg_guard pmg_guard_sva i_sva (
    .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FRM_VALID(FRM_VALID), .FWD_VALID(FWD_VALID), .FWD_OK(FWD_OK),
    .VIOL_EVENT(VIOL_EVENT), .PORT_ENABLE(PORT_ENABLE), .LOGICAL_ENABLE(LOGICAL_ENABLE),
    .SHUT_PERSIST_OUT(SHUT_PERSIST_OUT)
);

//--- bench/pmg_station.sv
module pmg_station (
    input wire logic mclk,
    output logic frm_valid = 1'b0,
    output logic [47:0] frm_src = 48'h0,
    output logic [11:0] frm_vlan = 12'h001,
    output logic link_up = 1'b1,
    output logic move_valid = 1'b0,
    output logic [47:0] move_src = 48'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // one frame source, held for exactly one edge
    task automatic send(input logic [47:0] src);
        @(posedge mclk);
        frm_valid <= 1'b1;
        frm_src <= src;
        @(posedge mclk);
        frm_valid <= 1'b0;
        frm_src <= ~src; // no stale source between frames
    endtask : send
    // same source seen on a neighbour port
    task automatic move(input logic [47:0] src);
        @(posedge mclk);
        move_valid <= 1'b1;
        move_src <= src;
        @(posedge mclk);
        move_valid <= 1'b0;
        move_src <= ~src; // idle pattern differs from last
    endtask : move
    // link level change
    task automatic link(input logic up);
        @(posedge mclk);
        link_up <= up;
    endtask : link
endmodule : pmg_station

//--- bench/test_port_source_mac_guard.sv
module test_port_source_mac_guard;
    import pmg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 10; // short second keeps recovery quick
    logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, shut_out, frm_valid, link_up, move_valid, e;
    logic shut_in = 1'b0; // persisted shut flag from the always-on store
    logic [47:0] frm_src, move_src, a, b, c;
    logic [11:0] frm_vlan;
    logic fwd_valid, fwd_ok, viol, port_en, logic_en;
    int bad_count = 0, total_checks = 0, cyc = 0, n, seed = 65918;
    int maxn = 8192; // model: limit
    bit shut, rmode, rhit, stk; // model: shut, restrict mode, restricted, sticky
    logic [47:0] tab[$]; // model: secure sources
    int kind[$]; // model: 0 dynamic, 1 sticky
    pmg_guard #(.ENTRIES(8), .TICK_CYCLES(TICK)) i_dut (
        .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SHUT_PERSIST_IN(shut_in), .SHUT_PERSIST_OUT(shut_out),
        .FRM_VALID(frm_valid), .FRM_SRC(frm_src), .FRM_VLAN(frm_vlan), .LINK_UP(link_up),
        .MOVE_VALID(move_valid), .MOVE_SRC(move_src), .FWD_VALID(fwd_valid),
        .FWD_OK(fwd_ok), .VIOL_EVENT(viol), .PORT_ENABLE(port_en),
        .LOGICAL_ENABLE(logic_en)
    );
    pmg_station i_sta (
        .mclk(mclk), .frm_valid(frm_valid), .frm_src(frm_src), .frm_vlan(frm_vlan),
        .link_up(link_up), .move_valid(move_valid), .move_src(move_src)
    );
    // free-running core clock
    initial begin
        forever #10 mclk = ~mclk;
    end
    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    // single-bit and word comparisons
    task automatic chk1(input string nm, input logic ex, input logic sn);
        total_checks++;
        if (sn !== ex) begin
            bad_count++;
            $display("Error %s expected %b seen %b", nm, ex, sn);
        end
    endtask : chk1
    task automatic chk32(input string nm, input logic [31:0] ex, input logic [31:0] sn);
        total_checks++;
        if (sn !== ex) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, ex, sn);
        end
    endtask : chk32
    // apb transfer, held until pready at a rising edge
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
        apb(1'b0, ad, 32'h0);
        chk32("read data", ex, q);
    endtask : rd
    task automatic cnt();
        apb(1'b0, OFF_STATUS, 32'h0);
        chk32("entry count", 32'(tab.size()), {21'h0, q[10:0]});
    endtask : cnt
    // frame against the behavioural table
    task automatic frame(input logic [47:0] s);
        int f[$];
        bit ok;
        bit vi;
        f = tab.find_first_index(x) with (x == s);
        ok = 1'b0;
        vi = 1'b0;
        if (f.size() != 0) begin // known source
            ok = !shut;
        end else if (!shut && !rhit && tab.size() < maxn) begin // room: learn
            tab.push_back(s);
            kind.push_back(int'(stk));
            ok = 1'b1;
        end else if (!shut) begin // full: violation
            vi = !rmode;
            shut = !rmode;
            rhit = rmode;
        end
        i_sta.send(s);
        #1;
        chk1("fwd_valid", 1'b1, fwd_valid);
        chk1("fwd_ok", ok, fwd_ok);
        chk1("viol_event", vi, viol);
        @(posedge mclk);
        #1;
        chk1("port_enable", !shut, port_en);
        chk1("logical_enable", !shut && !rhit, logic_en);
    endtask : frame
    // link bounce drops dynamic entries
    task automatic linkdrop();
        i_sta.link(1'b0);
        i_sta.link(1'b1);
        for (int i = tab.size() - 1; i >= 0; i--) begin
            if (kind[i] == 0) begin
                tab.delete(i);
                kind.delete(i);
            end
        end
        rhit = rhit && (tab.size() >= maxn);
        cnt();
    endtask : linkdrop
    task automatic do_reset();
        rst <= 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : do_reset
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    // main sequence
    initial begin
        a = 48'({$random(seed), $random(seed)});
        b = 48'({$random(seed), $random(seed)});
        c = 48'({$random(seed), $random(seed)});
        do_reset();
        rd(OFF_MAX, 32'd8192);
        rd(OFF_AGE, 32'd300);
        rd(OFF_ACCESS_VLAN, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk1("pslverr", 1'b1, e);
        apb(1'b1, OFF_MAX, 32'h0);
        rd(OFF_MAX, 32'd8192);
        apb(1'b1, OFF_MAX, 32'h2);
        maxn = 2;
        apb(1'b1, OFF_CTRL, 32'h1);
        frame(a);
        frame(b);
        frame(a);
        cnt();
        frame(c);
        frame(a);
        apb(1'b1, OFF_CMD, 32'h4);
        shut = 1'b0;
        frame(a);
        apb(1'b1, OFF_CTRL, 32'h3);
        rd(OFF_CTRL, 32'h1);
        i_sta.move(a);
        tab.delete(0);
        kind.delete(0);
        cnt();
        frame(a);
        apb(1'b1, OFF_CTRL, 32'h5);
        stk = 1'b1;
        foreach (kind[i]) kind[i] = 1;
        linkdrop();
        apb(1'b1, OFF_CTRL, 32'h1);
        stk = 1'b0;
        foreach (kind[i]) kind[i] = 0;
        linkdrop();
        apb(1'b1, OFF_CTRL, 32'h9);
        rmode = 1'b1;
        frame(a);
        frame(b);
        frame(c);
        linkdrop();
        apb(1'b1, OFF_RECOV, 32'h2);
        apb(1'b1, OFF_CTRL, 32'h11);
        rmode = 1'b0;
        frame(a);
        frame(b);
        frame(c);
        for (n = 0; n < 100 && port_en !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        chk1("recovery window", 1'b1, logic'(n >= TICK - 2 && n <= 3 * TICK));
        shut = 1'b0;
        rd(OFF_CTRL, 32'h11);
        frame(c);
        apb(1'b1, OFF_RECOV, 32'h3);
        for (n = 0; n < 100 && port_en !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        chk1("restarted window", 1'b1, logic'(n >= 2 * TICK && n <= 3 * TICK));
        shut = 1'b0;
        frame(c);
        apb(1'b1, OFF_CTRL, 32'h11);
        repeat (4 * TICK) @(posedge mclk);
        #1;
        chk1("no timer after change", 1'b0, port_en);
        apb(1'b1, OFF_CMD, 32'h4);
        shut = 1'b0;
        apb(1'b1, OFF_CMD, 32'h8);
        #1;
        chk1("admin down", 1'b0, port_en);
        chk1("admin not persisted", 1'b0, shut_out);
        shut_in <= 1'b1;
        do_reset();
        #1;
        chk1("port after restart", 1'b0, port_en);
        chk1("shut_persist_out", 1'b1, shut_out);
        finish_test();
    end
endmodule : test_port_source_mac_guard
